// [hw/rsq_defs.svh]
`ifndef RSQ_DEFS_SVH
`define RSQ_DEFS_SVH
`define RSQ_MIN_PULSE      4
`define RSQ_EXTEND_CYCLES  4096
`define RSQ_LOCK_DELAY     2
`define RSQ_CFG_WIDTH      16
`define RSQ_CLK_PERIOD_NS  8
`define RSQ_OSC_UP_US      100
`define RSQ_PLL_LOCK_US    100
`endif

// [hw/rsq_pkg.sv]
`include "rsq_defs.svh"
package rsq_pkg;
    typedef enum logic [1:0] {
        RSQ_IDLE   = 2'b00,
        RSQ_PORLOW = 2'b01,
        RSQ_EXTEND = 2'b11
    } rsq_state_t;
endpackage

// [hw/rsq_sequencer.sv]
`include "rsq_defs.svh"
module rsq_sequencer
    import rsq_pkg::*;
#(
    parameter int CFG_WIDTH  = `RSQ_CFG_WIDTH,
    parameter int MIN_PULSE  = `RSQ_MIN_PULSE,
    parameter int EXTEND     = `RSQ_EXTEND_CYCLES,
    parameter int LOCK_DELAY = `RSQ_LOCK_DELAY
) (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    // Reset pins, open drain for hard and soft reset
    input  wire logic                 power_on_reset_n,
    input  wire logic                 hard_reset_n_in,
    output logic                      hard_reset_n_out,
    output logic                      hard_reset_n_oe_n,
    input  wire logic                 soft_reset_n_in,
    output logic                      soft_reset_n_out,
    output logic                      soft_reset_n_oe_n,
    // Internal results
    output logic                      internal_reset_n,
    output logic                      soft_reset_req,
    // Configuration word
    input  wire logic [CFG_WIDTH-1:0] cfg_pins,
    output logic      [CFG_WIDTH-1:0] cfg_word,
    output logic                      cfg_locked
);
    localparam int CW = $clog2(EXTEND + 1);

    logic [2:0]     pins_sync;
    rsq_state_t     state;
    rsq_state_t     next_state;
    logic [CW-1:0]  count;
    logic [CW-1:0]  next_count;
    logic [2:0]     hard_width;
    logic [2:0]     soft_width;
    logic [2:0]     por_width;
    logic           hard_valid;
    logic           por_valid;
    logic [1:0]     lock_count;
    logic [CFG_WIDTH-1:0] cfg_sync;
    logic [2:0]     drive_hist;

    rsq_sync #(
        .WIDTH(3)
    ) u_sync (
        .clock   (clock),
        .rst_n   (rst_n),
        .async_in({power_on_reset_n, hard_reset_n_in, soft_reset_n_in}),
        .sync_out(pins_sync)
    );

    // Straps are pins too; they pass the same two stages
    rsq_sync #(
        .WIDTH(CFG_WIDTH)
    ) u_cfg_sync (
        .clock   (clock),
        .rst_n   (rst_n),
        .async_in(cfg_pins),
        .sync_out(cfg_sync)
    );

    // Hard and soft pins held low during power-on and extension
    wire drive_low = (state != RSQ_IDLE);

    // Own pull-down comes back on the inputs; ignore it until the
    // released level has passed both synchroniser stages
    wire own_drive = drive_low || (|drive_hist);

    // Active low: a synchronised zero means asserted
    wire por_act      = ~pins_sync[2];
    wire hard_pin_low = ~pins_sync[1];
    wire hard_act     = hard_pin_low && !own_drive;
    wire soft_act     = ~pins_sync[0] && !own_drive;
    // Capture follows the pin level, own drive included
    wire pin_low      = por_act || hard_pin_low;

    function automatic logic [2:0] width_step(input logic act, input logic [2:0] w);
        if (!act)
            return 3'h0;
        else if (w == 3'(MIN_PULSE))
            return w;
        else
            return w + 3'h1;
    endfunction

    // One below the minimum plus the current active clock makes the full width
    wire hard_long = (hard_width >= 3'(MIN_PULSE - 1));
    wire soft_long = (soft_width >= 3'(MIN_PULSE - 1));
    wire por_long  = (por_width  >= 3'(MIN_PULSE - 1));

    // Release edges of pulses that met the minimum width
    wire hard_rel = hard_valid && !hard_act;
    wire por_rel  = por_valid && !por_act;
    wire any_act  = por_act || hard_act;

    wire ext_done = (count == CW'(EXTEND - 1));

    always_comb begin
        next_state = state;
        next_count = count;
        unique case (state)
            RSQ_IDLE: begin
                if (por_act) begin
                    next_state = RSQ_PORLOW;
                end else if (hard_rel) begin
                    next_state = RSQ_EXTEND;
                    next_count = '0;
                end
            end
            RSQ_PORLOW: begin
                if (por_rel) begin
                    next_state = RSQ_EXTEND;
                    next_count = '0;
                end else if (!por_act) begin
                    // Short pulse: nothing recognised
                    next_state = RSQ_IDLE;
                end
            end
            RSQ_EXTEND: begin
                if (any_act) begin
                    // Reassertion restarts the extension count
                    next_state = por_act ? RSQ_PORLOW : RSQ_EXTEND;
                    next_count = '0;
                end else if (ext_done) begin
                    next_state = RSQ_IDLE;
                    next_count = '0;
                end else begin
                    next_count = count + CW'(1);
                end
            end
            default: begin
                next_state = RSQ_IDLE;
                next_count = '0;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state      <= RSQ_PORLOW;
            count      <= '0;
            hard_width <= 3'h0;
            soft_width <= 3'h0;
            por_width  <= 3'h0;
            hard_valid <= 1'b0;
            por_valid  <= 1'b0;
            drive_hist <= 3'h7;
        end else begin
            drive_hist <= {drive_hist[1:0], drive_low};
            state      <= next_state;
            count      <= next_count;
            hard_width <= width_step(hard_act, hard_width);
            soft_width <= width_step(soft_act, soft_width);
            por_width  <= width_step(por_act, por_width);
            hard_valid <= hard_act && hard_long;
            por_valid  <= por_act && por_long;
        end
    end

    // Next state covers the clock in which a release is recognised
    wire int_hold = drive_low || (next_state != RSQ_IDLE) || hard_act;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            hard_reset_n_oe_n <= 1'b0;
            soft_reset_n_oe_n <= 1'b0;
            internal_reset_n  <= 1'b0;
            soft_reset_req    <= 1'b0;
        end else begin
            hard_reset_n_oe_n <= ~drive_low;
            soft_reset_n_oe_n <= ~drive_low;
            internal_reset_n  <= ~int_hold;
            soft_reset_req    <= soft_act && soft_long && !drive_low;
        end
    end

    assign hard_reset_n_out = 1'b0;
    assign soft_reset_n_out = 1'b0;

    // Config word follows pins during reset, freezes two clocks after release
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lock_count <= 2'h0;
            cfg_locked <= 1'b0;
            cfg_word   <= '0;
        end else if (pin_low) begin
            lock_count <= 2'h0;
            cfg_locked <= 1'b0;
            cfg_word   <= cfg_sync;
        end else if (!cfg_locked) begin
            cfg_word   <= cfg_sync;
            lock_count <= lock_count + 2'h1;
            cfg_locked <= (lock_count == 2'(LOCK_DELAY - 1));
        end
    end
endmodule // rsq_sequencer

// [hw/rsq_sync.sv]
module rsq_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // Reset to asserted: no false release seen while the stages refill
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // rsq_sync

// [sim/reset_sequencer_config_latch_bench.sv]
module reset_sequencer_config_latch_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int EXT = 16;
    localparam int LENS [3] = '{3, 4, 8};
    logic        clock = 1'b0, rst_n = 1'b0, por_n = 1'b0, hcmd = 1'b1, scmd = 1'b1;
    logic        hw, sw, hoe, soe, irst, sreq, lck;
    logic [15:0] cfg = 16'h0000, word, rnd = 16'h002D;
    logic [15:0] exp_q[$];
    int          err_count = 0, n_checks = 0, cyc = 0, n;
    always #4 clock = ~clock;
    rsq_board brd (.hard_cmd_n(hcmd), .soft_cmd_n(scmd), .hard_oe_n(hoe), .soft_oe_n(soe), .hard_wire(hw),
        .soft_wire(sw));
    rsq_sequencer #(.EXTEND(EXT)) dut (.clock(clock), .rst_n(rst_n), .power_on_reset_n(por_n),
        .hard_reset_n_in(hw), .hard_reset_n_out(), .hard_reset_n_oe_n(hoe), .soft_reset_n_in(sw),
        .soft_reset_n_out(), .soft_reset_n_oe_n(soe), .internal_reset_n(irst), .soft_reset_req(sreq),
        .cfg_pins(cfg), .cfg_word(word), .cfg_locked(lck));
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wait_hi(input bit on_int, output int cnt);
        cnt = 0;
        while ((on_int ? irst : hoe) !== 1'b1 && cnt < 100) begin
            @(negedge clock);
            cnt++;
        end
    endtask
    task automatic hard_pulse(input int len);
        int k;
        rnd = lfsr(rnd);
        cfg = rnd;
        exp_q.push_back(rnd);
        hcmd = 1'b0;
        repeat (len) @(negedge clock);
        hcmd = 1'b1;
        repeat (3) @(negedge clock);
        chk("internal", 16'(len < 4), 16'(irst));
        wait_hi(1'b1, k);
        chk("extension", 16'h0001, 16'(len < 4 ? k == 0 : k > EXT - 5 && k < 100));
    endtask
    task automatic soft_pulse(input int len);
        int seen;
        seen = 0;
        scmd = 1'b0;
        repeat (len) @(negedge clock) seen += int'(sreq === 1'b1);
        scmd = 1'b1;
        repeat (4) @(negedge clock) seen += int'(sreq === 1'b1);
        chk("soft request", 16'(len >= 4), 16'(seen > 0));
    endtask
    // Each lock must hold the straps present at release; read once settled
    always @(posedge lck) begin
        @(negedge clock);
        if (exp_q.size() > 0)
            chk("config word", exp_q.pop_front(), word);
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            report_and_stop();
        end
    end
    initial begin
        repeat (8) @(negedge clock);
        rst_n = 1'b1;
        repeat (20) @(negedge clock) begin
            rnd = lfsr(rnd);
            cfg = rnd;
        end
        exp_q.push_back(cfg);
        por_n = 1'b1;
        wait_hi(1'b0, n);
        chk("pin hold", 16'h0001, 16'(n >= EXT && n < 100));
        chk("internal", 16'h0001, 16'(irst));
        foreach (LENS[i]) begin
            repeat (8) @(negedge clock);
            hard_pulse(LENS[i]);
            repeat (8) @(negedge clock);
            soft_pulse(LENS[i]);
        end
        repeat (10) @(negedge clock);
        chk("pending words", 16'h0000, 16'(exp_q.size()));
        report_and_stop();
    end
endmodule // reset_sequencer_config_latch_bench

// [sim/rsq_board.sv]
module rsq_board (
    // Board requests
    input wire logic hard_cmd_n,
    input wire logic soft_cmd_n,
    // Device pull-downs
    input wire logic hard_oe_n,
    input wire logic soft_oe_n,
    // Resolved lines
    output logic     hard_wire,
    output logic     soft_wire
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pull-ups win once nobody pulls low
    assign hard_wire = hard_cmd_n & hard_oe_n;
    assign soft_wire = soft_cmd_n & soft_oe_n;
endmodule // rsq_board

// [sim/rsq_sequencer_sva.sv]
module rsq_sequencer_sva #(
    parameter int CFG_WIDTH = 16,
    parameter int EXTEND    = 16
) (
    // Clock and reset
    input wire logic                 clock,
    input wire logic                 rst_n,
    // Reset pins
    input wire logic                 power_on_reset_n,
    input wire logic                 hard_reset_n_in,
    input wire logic                 soft_reset_n_in,
    input wire logic                 hard_reset_n_oe_n,
    // Results
    input wire logic                 internal_reset_n,
    input wire logic                 soft_reset_req,
    input wire logic [CFG_WIDTH-1:0] cfg_pins,
    input wire logic [CFG_WIDTH-1:0] cfg_word,
    input wire logic                 cfg_locked
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int EXT_LO = EXTEND - 12;
    localparam int EXT_HI = EXTEND + 24;
    logic [3:0] low_cnt;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // Saturates so a long hold never wraps into a short one
    always_ff @(posedge clock) begin
        if (!rst_n || hard_reset_n_in)
            low_cnt <= 4'h0;
        else if (low_cnt != 4'hF)
            low_cnt <= low_cnt + 4'h1;
    end
    sequence s_ext(sig);
        !sig [*8] ##[EXT_LO:EXT_HI] sig;
    endsequence
    property p_por; $rose(power_on_reset_n) |-> s_ext(hard_reset_n_oe_n); endproperty
    a_por: assert property (p_por) else $error("pin hold wrong");
    property p_hext; $rose(hard_reset_n_in) && $past(hard_reset_n_oe_n) && low_cnt > 4'h3 |-> ##3 s_ext(internal_reset_n); endproperty
    a_hext: assert property (p_hext) else $error("hard extension wrong");
    property p_short; $rose(hard_reset_n_in) && low_cnt < 4'h4 |-> ##3 internal_reset_n [*8]; endproperty
    a_short: assert property (p_short) else $error("short pulse acted on");
    property p_int; !hard_reset_n_oe_n && !$past(hard_reset_n_oe_n) |-> !internal_reset_n; endproperty
    a_int: assert property (p_int) else $error("internal reset free");
    property p_cap; (!power_on_reset_n || !hard_reset_n_in) [*4] |=> cfg_word == $past(cfg_pins, 3); endproperty
    a_cap: assert property (p_cap) else $error("word not captured");
    property p_frz; cfg_locked && $past(cfg_locked) |-> $stable(cfg_word); endproperty
    a_frz: assert property (p_frz) else $error("locked word moved");
    property p_lock; $rose(power_on_reset_n && hard_reset_n_in) |-> !cfg_locked [*2] ##[1:5] cfg_locked; endproperty
    a_lock: assert property (p_lock) else $error("lock timing wrong");
    property p_sreq; (!soft_reset_n_in && hard_reset_n_oe_n) [*6] |-> ##[0:4] soft_reset_req; endproperty
    a_sreq: assert property (p_sreq) else $error("soft reset missed");
endmodule // rsq_sequencer_sva

bind rsq_sequencer rsq_sequencer_sva #(.CFG_WIDTH(CFG_WIDTH), .EXTEND(EXTEND)) u_sva (.clock(clock), .rst_n(rst_n),
    .power_on_reset_n(power_on_reset_n), .hard_reset_n_in(hard_reset_n_in), .soft_reset_n_in(soft_reset_n_in),
    .hard_reset_n_oe_n(hard_reset_n_oe_n), .internal_reset_n(internal_reset_n), .soft_reset_req(soft_reset_req),
    .cfg_pins(cfg_pins), .cfg_word(cfg_word), .cfg_locked(cfg_locked));
